// file: rtl/sar_adc_pkg.sv
package sar_adc_pkg;
  // register byte addresses on the avalon bus (word aligned)
  localparam logic [3:0] OFF_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFF_RESULT = 4'h4;
  localparam logic [3:0] OFF_AMP_CTRL = 4'h8;
  // control/status field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_SPEED = 6;
  localparam int BIT_ON = 5;
  localparam int CH_LSB = 0;
  localparam int CH_W = 3;
  // amplifier control field positions
  localparam int BIT_SLOW = 3;
  localparam int BIT_GAIN = 2;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_AMP = 8'h00;
  // highest legal channel code
  localparam logic [2:0] CH_MAX = 3'h4;
  // sample phase length in converter clock ticks
  localparam int SAMPLE_TICKS = 4;
  localparam int RES_BITS = 8;

  typedef struct packed {
    logic speed;
    logic slow;
    logic gain;
    logic [2:0] channel;
  } conv_cfg_s;
endpackage : sar_adc_pkg

// file: rtl/sar_adc_sequencer.sv
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// - eight-bit successive approximation into result register
// - channel select routes one of five inputs
// - gain select applies fixed x8 amplifier
// - amplifier powered by converter_on, no delay
// - input at high reference gives FFh
// - input at low reference gives 00h
// - result is monotonic in input
// - sample phase then eight approximation cycles
// - conversions repeat continuously while on
// - converter_on set starts first conversion
// - done flag set at each completion
// - completion raises no interrupt
// - result held until next conversion ends
// - control write with converter_on set restarts conversion
// - done cleared by result read or control write
// - codes 000 to 100 select inputs
// - converter clock cpu/2, cpu, cpu/4
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int SAMPLE_LEN = SAMPLE_TICKS
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic comp_i,
  output logic [7:0] dac_code_o,
  output logic [2:0] mux_sel_o,
  output logic sample_o,
  output logic gain_en_o,
  output logic analog_on_o
);

  typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_APPROX} conv_state_e;

  conv_state_e state_r;
  conv_cfg_s cfg_r;
  logic on_r;
  logic done_r;
  logic [7:0] result_r;
  logic [7:0] trial_r;
  logic [2:0] bit_idx_r;
  logic [7:0] samp_cnt_r;
  logic [1:0] div_r;
  logic tick;
  logic ack_r;
  logic wr_ctrl;
  logic wr_amp;
  logic rd_result;
  logic restart;
  logic conv_end;
  logic [7:0] ctrl_rd;
  logic [7:0] amp_rd;

  // one-cycle wait then ack; waitrequest deasserts for exactly one edge
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
  end

  assign wr_ctrl = ack_r && avs_write_i && avs_byteenable_i[0]
                   && avs_address_i == OFF_CTRL_STATUS;
  assign wr_amp = ack_r && avs_write_i && avs_byteenable_i[0]
                  && avs_address_i == OFF_AMP_CTRL;
  assign rd_result = ack_r && avs_read_i && avs_address_i == OFF_RESULT;
  assign restart = wr_ctrl && avs_writedata_i[BIT_ON];

  // waitrequest from a flop: high unless this cycle is the ack
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_r);
  end

  // control and amplifier settings
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      on_r <= RST_CTRL[BIT_ON];
      cfg_r <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        on_r <= avs_writedata_i[BIT_ON];
        cfg_r.speed <= avs_writedata_i[BIT_SPEED];
        cfg_r.channel <= avs_writedata_i[CH_LSB +: CH_W];
      end
      if (wr_amp)
      begin
        cfg_r.slow <= avs_writedata_i[BIT_SLOW];
        cfg_r.gain <= avs_writedata_i[BIT_GAIN];
      end
    end
  end

  // converter clock as enable pulse; slow overrides speed
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end

  always_comb
  begin
    if (cfg_r.slow)
      tick = (div_r == 2'h3);
    else if (cfg_r.speed)
      tick = 1'b1;
    else
      tick = div_r[0];
  end

  assign conv_end = on_r && !restart && state_r == ST_APPROX && tick
                    && bit_idx_r == 3'h0;

  // sequencer: sample, then eight approximation steps, forever while on
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ST_OFF;
      trial_r <= 8'h00;
      dac_code_o <= 8'h00;
      bit_idx_r <= 3'h7;
      samp_cnt_r <= 8'h00;
    end
    else if (!on_r || restart)
    begin
      // abort; a restart reenters sample with fresh counters
      state_r <= restart ? ST_SAMPLE : ST_OFF;
      trial_r <= 8'h80;
      dac_code_o <= 8'h80;
      bit_idx_r <= 3'h7;
      samp_cnt_r <= 8'h00;
    end
    else if (tick)
    begin
      case (state_r)
        ST_OFF:
        begin
          state_r <= ST_SAMPLE;
          samp_cnt_r <= 8'h00;
        end
        ST_SAMPLE:
        begin
          if (samp_cnt_r == 8'(SAMPLE_LEN - 1))
          begin
            state_r <= ST_APPROX;
            trial_r <= 8'h80;
            dac_code_o <= 8'h80;
            bit_idx_r <= 3'h7;
          end
          else
            samp_cnt_r <= samp_cnt_r + 8'h01;
        end
        ST_APPROX:
        begin
          // comparator high means input at or above trial: keep the bit
          // dac code mirrors trial so the fastest tick sees the new code
          if (!comp_i)
          begin
            trial_r[bit_idx_r] <= 1'b0;
            dac_code_o[bit_idx_r] <= 1'b0;
          end
          if (bit_idx_r != 3'h0)
          begin
            trial_r[bit_idx_r - 3'h1] <= 1'b1;
            dac_code_o[bit_idx_r - 3'h1] <= 1'b1;
            bit_idx_r <= bit_idx_r - 3'h1;
          end
          else
          begin
            state_r <= ST_SAMPLE;
            samp_cnt_r <= 8'h00;
          end
        end
        default:
          state_r <= ST_OFF;
      endcase
    end
  end

  // result latched only at conversion end; saturates naturally
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      result_r <= RST_RESULT;
    else if (conv_end)
      result_r <= comp_i ? trial_r : (trial_r & 8'hFE);
  end

  // done flag: completion beats a clearing access in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      done_r <= RST_CTRL[BIT_DONE];
    else if (conv_end)
      done_r <= 1'b1;
    else if (rd_result || wr_ctrl)
      done_r <= 1'b0;
  end

  assign ctrl_rd = {done_r, cfg_r.speed, on_r, 2'b00, cfg_r.channel};
  assign amp_rd = {4'h0, cfg_r.slow, cfg_r.gain, 2'b00};

  // read data registered at the acking edge; unmapped reads return zero
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !ack_r)
    begin
      case (avs_address_i)
        OFF_CTRL_STATUS: avs_readdata_o <= {24'h000000, ctrl_rd};
        OFF_RESULT: avs_readdata_o <= {24'h000000, result_r};
        OFF_AMP_CTRL: avs_readdata_o <= {24'h000000, amp_rd};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // input mux; codes above four clamp to the last input
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mux_sel_o <= 3'h0;
    else
      mux_sel_o <= (cfg_r.channel > CH_MAX) ? CH_MAX : cfg_r.channel;
  end

  // sample switch closed only in the sample phase
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sample_o <= 1'b0;
    else
      sample_o <= (state_r == ST_SAMPLE);
  end

  // amplifier only ever runs with the converter powered
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      gain_en_o <= 1'b0;
    else
      gain_en_o <= cfg_r.gain && on_r;
  end

  // analog power follows converter_on
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      analog_on_o <= 1'b0;
    else
      analog_on_o <= on_r;
  end
  // no interrupt output exists at all; polling only

  AST_DONE_ON_END: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    conv_end |=> done_r) else $error("done not set");
  AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !conv_end |=> $stable(result_r)) else $error("result moved");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_result && !conv_end) |=> !done_r) else $error("no clear");
  AST_RESTART: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    restart |=> state_r == ST_SAMPLE && samp_cnt_r == 8'h00)
    else $error("no restart");
  AST_OFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!on_r && !restart) |=> state_r == ST_OFF) else $error("runs off");
  AST_SAMPLE_THEN_APPROX: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (state_r == ST_SAMPLE && tick && on_r && !restart
     && samp_cnt_r == 8'(SAMPLE_LEN - 1)) |=> state_r == ST_APPROX
     && trial_r == 8'h80) else $error("bad phase");
  AST_AMP_POWER: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    gain_en_o |-> analog_on_o) else $error("amp unpowered");
  AST_MUX_RANGE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    mux_sel_o <= CH_MAX) else $error("bad channel");
  AST_FAST_TICK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cfg_r.speed && !cfg_r.slow) |-> tick) else $error("tick");

  // front end pins against internal state
  AST_DAC_MIRROR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    dac_code_o == trial_r) else $error("dac lags trial");
  AST_SAMPLE_PIN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_r == ST_SAMPLE |=> sample_o) else $error("no sample");
  AST_HOLD_PIN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_r != ST_SAMPLE |=> !sample_o) else $error("sampling");
  AST_GAIN_FOLLOWS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cfg_r.gain && on_r) |=> gain_en_o) else $error("no gain");
  AST_ANALOG_UP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    on_r |=> analog_on_o) else $error("analog off");
  AST_ANALOG_DOWN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !on_r |=> !analog_on_o) else $error("analog on");
  AST_MUX_FOLLOW: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cfg_r.channel <= CH_MAX |=> mux_sel_o == $past(cfg_r.channel))
    else $error("mux wrong");

  // flag behaviour on software access and when off
  AST_CLEAR_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_ctrl && !conv_end) |=> !done_r) else $error("write kept");
  AST_IDLE_NO_DONE: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (!on_r && !done_r) |=> !done_r) else $error("done while off");

  // bus handshake: one wait cycle, then a single low cycle
  AST_WAIT_ONE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ((avs_read_i || avs_write_i) && !ack_r) |=> !avs_waitrequest_o)
    else $error("no answer");
  AST_WAIT_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("stray answer");

endmodule : sar_adc_sequencer

// file: sim/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb;
  import sar_adc_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic comp_i;
  logic [31:0] rdata;
  logic waitr;
  logic [7:0] dac_code;
  logic [2:0] mux_sel;
  logic sample;
  logic gain_en;
  logic analog_on;
  logic [31:0] q;
  logic [7:0] ain [5] = '{8'h00, 8'h5A, 8'hFF, 8'h01, 8'h80};
  int fail_count = 0;
  int total_checks = 0;

  sar_adc_sequencer #(.SAMPLE_LEN(SAMPLE_TICKS)) DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitr), .comp_i(comp_i), .dac_code_o(dac_code),
    .mux_sel_o(mux_sel), .sample_o(sample), .gain_en_o(gain_en),
    .analog_on_o(analog_on));

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  // ideal x8 stage, saturates at full scale
  function automatic logic [7:0] scale(input logic [7:0] v, input logic g);
    if (g && v > 8'h1F) return 8'hFF;
    return g ? {v[4:0], 3'h0} : v;
  endfunction : scale

  // ideal comparator, settles within the cycle the code is shown
  assign comp_i = scale(ain[mux_sel > 3'h4 ? 3'h4 : mux_sel], gain_en)
                  >= dac_code;

  // one avalon access, held until waitrequest is seen low
  task automatic acc(input logic [3:0] a, input logic w,
                     input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wd <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (waitr !== 1'b0 && n < 50);
    r = rdata;
    `CHK(waitr, 1'b0)
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc

  // polls the done flag, then checks the result and flag clearing
  task automatic conv(input logic [7:0] e, input logic chk);
    for (int i = 0; i < 100; i++)
    begin
      acc(OFF_CTRL_STATUS, 1'b0, 8'h00, q);
      if (q[BIT_DONE] === 1'b1) break;
    end
    `CHK(q[BIT_DONE], 1'b1)
    `CHK(analog_on, 1'b1)
    acc(OFF_RESULT, 1'b0, 8'h00, q);
    if (chk) `CHK(q, {24'h0, e})
    acc(OFF_CTRL_STATUS, 1'b0, 8'h00, q);
    `CHK(q[BIT_DONE], 1'b0)
  endtask : conv

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // watchdog at 50000 cycles, far beyond the roughly one thousand cycles the tests need
  initial
  begin
    #1000000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // reset values, unmapped place, masked write
    acc(OFF_CTRL_STATUS, 1'b0, 8'h00, q); `CHK(q, {24'h0, RST_CTRL})
    acc(OFF_RESULT, 1'b0, 8'h00, q); `CHK(q, {24'h0, RST_RESULT})
    acc(OFF_AMP_CTRL, 1'b0, 8'h00, q); `CHK(q, {24'h0, RST_AMP})
    acc(4'hC, 1'b0, 8'h00, q); `CHK(q, 32'h0)
    be <= 4'h0;
    acc(OFF_AMP_CTRL, 1'b1, 8'h04, q);
    be <= 4'hF;
    acc(OFF_AMP_CTRL, 1'b0, 8'h00, q); `CHK(q, 32'h0)
    `CHK(analog_on, 1'b0)
    $display("test regs done");
    // every legal channel code plus clamped code 5, end points of the range included
    for (int c = 0; c < 5; c++)
    begin
      acc(OFF_CTRL_STATUS, 1'b1, 8'(8'h20 | c), q);
      conv(ain[c], 1'b1);
      `CHK(mux_sel, 3'(c))
      conv(ain[c], 1'b1);
    end
    acc(OFF_CTRL_STATUS, 1'b1, 8'h25, q);
    conv(ain[4], 1'b1);
    `CHK(mux_sel, CH_MAX)
    $display("test channels done");
    // gain and slow clock, first result after a change discarded
    acc(OFF_CTRL_STATUS, 1'b1, 8'h23, q);
    acc(OFF_AMP_CTRL, 1'b1, 8'h04, q);
    conv(8'h00, 1'b0);
    conv(8'h08, 1'b1);
    `CHK(gain_en, 1'b1)
    acc(OFF_AMP_CTRL, 1'b1, 8'h0C, q);
    conv(8'h00, 1'b0);
    conv(8'h08, 1'b1);
    acc(OFF_AMP_CTRL, 1'b0, 8'h00, q); `CHK(q, 32'h0C)
    $display("test gain done");
    // control write with converter on aborts and clears done
    conv(8'h08, 1'b1);
    repeat (200) @(posedge clk_i);
    acc(OFF_CTRL_STATUS, 1'b1, 8'h23, q);
    acc(OFF_CTRL_STATUS, 1'b0, 8'h00, q);
    `CHK(q[BIT_DONE], 1'b0)
    `CHK(q[7:0], 8'h23)
    conv(8'h08, 1'b1);
    // switched off: no further completions
    acc(OFF_CTRL_STATUS, 1'b1, 8'h03, q);
    repeat (300) @(posedge clk_i);
    acc(OFF_CTRL_STATUS, 1'b0, 8'h00, q);
    `CHK(q[BIT_DONE], 1'b0)
    `CHK(analog_on, 1'b0)
    $display("test abort done");
    wrap_up();
  end
endmodule : tb
